// [wsc_pkg.sv]
// Shared constants, types and decode functions of the waveform sequence controller
// Notes on behaviour
// [RULE1] Status bits 26:25 report the execution state
// [RULE2] Status bits 24:0 report the running entry
// [RULE3] Block read returns consecutive entries from index
// [RULE4] Sequence mode starts at the sequence start index
// [RULE5] Dynamic jumps only after the first sequence
// [RULE6] Dynamic enable bit is writable and readable
// [RULE7] Dynamic off: selection changes only while stopped
// [RULE8] Dynamic on: next selection changes while running
// [RULE9] External port value is next entry index
// [RULE10] Host select sets next entry when dynamic
// [RULE11] Scenario mode starts at the scenario start index
// [RULE12] Scenario advance mode is writable and readable
// [RULE13] Scenario repeats loop count times, one minimum
// [RULE14] Sequence loop count comes from first entry
// [RULE15] Advance codes: auto, conditional, repeat, single
package wsc_pkg;

  // ****************************************************************
  // Widths and field positions
  // ****************************************************************
  localparam int IDX_W = 25;          // Sequence table index width
  localparam int CNT_W = 32;          // Loop counter width
  localparam int ADV_W = 4;           // Advance mode field width
  localparam int ENTRY_W = 64;        // Stored entry: control word over loop count
  localparam int CTRL_LO = 32;        // Control word starts here inside an entry
  localparam int END_SEQ_BIT = 30;    // End-of-sequence marker in control word
  localparam int END_SCEN_BIT = 29;   // End-of-scenario marker in control word
  localparam int STAT_STATE_LO = 25;  // State field position in status word
  localparam int STAT_RSV_W = 5;      // Reserved top bits of status word

  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic [1:0] CODE_IDLE = 2'h0;
  localparam logic [1:0] CODE_WAIT_TRIG = 2'h1;
  localparam logic [1:0] CODE_RUN = 2'h2;
  localparam logic [1:0] CODE_WAIT_ADV = 2'h3;
  localparam logic [ADV_W-1:0] ADV_AUTO = 4'h0;
  localparam logic [ADV_W-1:0] ADV_COND = 4'h1;
  localparam logic [ADV_W-1:0] ADV_REPEAT = 4'h2;
  localparam logic [ADV_W-1:0] ADV_SINGLE = 4'h3;
  localparam logic [ADV_W-1:0] ADV_RESET = ADV_AUTO;
  localparam logic DYN_RESET = 1'b0;
  localparam logic [CNT_W-1:0] LOOP_ONE = 32'h1;
  localparam logic [IDX_W-1:0] IDX_ONE = 25'h1;

  // Gray order along idle, armed, running, parked
  typedef enum logic [1:0] {
    WSC_IDLE = 2'b00,
    WSC_WAIT_TRIG = 2'b01,
    WSC_RUN = 2'b11,
    WSC_WAIT_ADV = 2'b10
  } wsc_state_type;

  // Status code as seen by software, independent of the state encoding
  function automatic logic [1:0] wsc_state_code(input wsc_state_type s);
    case (s)
      WSC_WAIT_TRIG: wsc_state_code = CODE_WAIT_TRIG;
      WSC_RUN: wsc_state_code = CODE_RUN;
      WSC_WAIT_ADV: wsc_state_code = CODE_WAIT_ADV;
      default: wsc_state_code = CODE_IDLE;
    endcase
  endfunction

  // A loop count of zero is outside the valid range and runs once
  function automatic logic [CNT_W-1:0] wsc_loops_min1(input logic [CNT_W-1:0] c);
    wsc_loops_min1 = (c == '0) ? LOOP_ONE : c;
  endfunction

endpackage

// [wsc_tbl_if.sv]
// Sequence table access signals between the controller and its table memory
`timescale 1ns/1ps
interface wsc_tbl_if #(
  parameter int AW = 8
);
  import wsc_pkg::*;
  logic wr_en;                 // Write strobe
  logic [AW-1:0] wr_addr;      // Write index
  logic [ENTRY_W-1:0] wr_data; // Write entry
  logic [AW-1:0] rd_addr_a;    // Playback read index
  logic [ENTRY_W-1:0] rd_data_a;
  logic [AW-1:0] rd_addr_b;    // Block read index
  logic [ENTRY_W-1:0] rd_data_b;
  modport mem (input wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
    output rd_data_a, rd_data_b);
  modport user (output wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
    input rd_data_a, rd_data_b);
endinterface

// [wsc_table.sv]
// Sequence table storage with one write port and two asynchronous read ports
`timescale 1ns/1ps
module wsc_table
  import wsc_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic clk,
  wsc_tbl_if.mem tbl
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Entries are not reset; software loads them before playback
  logic [ENTRY_W-1:0] mem_q [2**AW];

  // Write port
  always_ff @(posedge clk) begin
    if (tbl.wr_en) begin
      mem_q[tbl.wr_addr] <= tbl.wr_data;
    end
  end

  // Reads are combinational so playback sees a new entry without a bubble
  assign tbl.rd_data_a = mem_q[tbl.rd_addr_a];
  assign tbl.rd_data_b = mem_q[tbl.rd_addr_b];

endmodule

// [wsc_sequencer.sv]
// Waveform sequence controller: playback state machine, dynamic select and block read
`timescale 1ns/1ps
module wsc_sequencer
  import wsc_pkg::*;
#(
  parameter int TBL_AW = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic play_start,
  input wire logic play_stop,
  input wire logic trigger_event,
  input wire logic advance_event,
  input wire logic entry_done,
  input wire logic table_scenario_play_mode,
  input wire logic [IDX_W-1:0] sequence_start_index,
  input wire logic [IDX_W-1:0] scenario_start_index,
  input wire logic [CNT_W-1:0] scenario_loop_count,
  input wire logic scenario_advance_mode_wr,
  input wire logic [ADV_W-1:0] scenario_advance_mode_wdata,
  output logic [ADV_W-1:0] scenario_advance_mode,
  input wire logic dynamic_select_enable_wr,
  input wire logic dynamic_select_enable_wdata,
  output logic dynamic_select_enable,
  input wire logic next_entry_select_wr,
  input wire logic [IDX_W-1:0] next_entry_select_index,
  input wire logic [IDX_W-1:0] dyn_port_index,
  input wire logic dyn_port_strobe,
  input wire logic tbl_wr_en,
  input wire logic [IDX_W-1:0] tbl_wr_index,
  input wire logic [ENTRY_W-1:0] tbl_wr_data,
  input wire logic table_block_read_req,
  input wire logic [IDX_W-1:0] table_block_read_index,
  input wire logic [IDX_W-1:0] table_block_read_length,
  output logic blk_busy,
  output logic blk_valid,
  output logic blk_last,
  output logic [ENTRY_W-1:0] blk_data,
  output logic [ENTRY_W-1:0] entry_data,
  output logic [CNT_W-1:0] sequencer_state_word
);

  // ****************************************************************
  // Table memory
  // ****************************************************************
  wsc_tbl_if #(.AW(TBL_AW)) tbl ();
  wsc_table #(.AW(TBL_AW)) u_table (.clk(clk), .tbl(tbl));

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wsc_state_type state_q, state_d;     // Playback state
  logic [IDX_W-1:0] idx_q, idx_d;      // Running entry
  logic [IDX_W-1:0] seq_first_q, seq_first_d; // First entry of current sequence
  logic seq_new_q, seq_new_d;          // Loop count of the sequence not yet taken
  logic [CNT_W-1:0] seq_loops_q, seq_loops_d;
  logic [CNT_W-1:0] scen_loops_q, scen_loops_d;
  logic [IDX_W-1:0] scen_start_q, scen_start_d; // Scenario start latched at start
  logic mode_scen_q, mode_scen_d;      // Play mode latched at start
  logic [ADV_W-1:0] adv_q;             // Scenario advance mode
  logic dyn_en_q;                      // Dynamic selection enable
  logic dyn_pend_q;                    // A dynamic selection waits
  logic [IDX_W-1:0] dyn_idx_q;         // Dynamically selected entry
  logic [IDX_W-1:0] port_idx_s1_q, port_idx_s2_q; // Port index synchroniser
  logic port_stb_s1_q, port_stb_s2_q, port_stb_s3_q; // Port strobe synchroniser
  logic blk_busy_q, blk_valid_q, blk_last_q;
  logic [ENTRY_W-1:0] blk_data_q;
  logic [IDX_W-1:0] blk_idx_q, blk_left_q;

  // ****************************************************************
  // Entry decode
  // ****************************************************************
  wire [ENTRY_W-1:0] cur_w = tbl.rd_data_a;
  wire end_seq_w = cur_w[CTRL_LO+END_SEQ_BIT];
  wire end_scen_w = cur_w[CTRL_LO+END_SCEN_BIT];
  // Loop count is only read on the first entry of a sequence [RULE14]
  wire [CNT_W-1:0] seq_loops_eff_w = seq_new_q ? wsc_loops_min1(cur_w[CNT_W-1:0]) : seq_loops_q;
  wire seq_more_w = seq_loops_eff_w > LOOP_ONE;
  wire done_w = (state_q == WSC_RUN) && entry_done;
  wire seq_end_w = done_w && end_seq_w && !seq_more_w;
  // A pending choice is taken only once a whole sequence has ended [RULE5] [RULE8]
  wire dyn_take_w = seq_end_w && dyn_en_q && dyn_pend_q;
  wire scen_end_w = seq_end_w && !dyn_take_w && mode_scen_q && end_scen_w;
  wire scen_more_w = scen_loops_q > LOOP_ONE;
  wire [CNT_W-1:0] scen_reload_w = wsc_loops_min1(scenario_loop_count);

  // ****************************************************************
  // Dynamic selection
  // ****************************************************************
  // Selections outside dynamic mode are dropped [RULE7]
  wire port_edge_w = port_stb_s2_q && !port_stb_s3_q;
  wire host_sel_w = next_entry_select_wr && dyn_en_q; // [RULE10]
  wire port_sel_w = port_edge_w && dyn_en_q; // [RULE9]
  // New selection wins over its own consumption in the same cycle
  wire dyn_pend_d = dyn_en_q && (host_sel_w || port_sel_w || (dyn_pend_q && !dyn_take_w));
  wire [IDX_W-1:0] dyn_idx_d = host_sel_w ? next_entry_select_index :
    (port_sel_w ? port_idx_s2_q : dyn_idx_q);

  // Port pins cross in by two flops; the index must be stable around its strobe
  always_ff @(posedge clk) begin
    port_idx_s1_q <= dyn_port_index;
    port_idx_s2_q <= port_idx_s1_q;
    port_stb_s1_q <= dyn_port_strobe;
    port_stb_s2_q <= port_stb_s1_q;
    port_stb_s3_q <= port_stb_s2_q;
  end

  // Software settings and pending choice
  always_ff @(posedge clk) begin
    if (srst) begin
      dyn_en_q <= DYN_RESET;
      adv_q <= ADV_RESET;
      dyn_pend_q <= 1'b0;
      dyn_idx_q <= '0;
    end else begin
      if (dynamic_select_enable_wr) begin
        dyn_en_q <= dynamic_select_enable_wdata; // [RULE6]
      end
      if (scenario_advance_mode_wr) begin
        adv_q <= scenario_advance_mode_wdata; // [RULE12]
      end
      dyn_pend_q <= dyn_pend_d;
      dyn_idx_q <= dyn_idx_d;
    end
  end

  // ****************************************************************
  // Playback state machine
  // ****************************************************************
  // Next-state logic; a jump also marks a new sequence start
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    seq_first_d = seq_first_q;
    seq_new_d = seq_new_q;
    seq_loops_d = seq_loops_q;
    scen_loops_d = scen_loops_q;
    scen_start_d = scen_start_q;
    mode_scen_d = mode_scen_q;
    case (state_q)
      WSC_IDLE: begin
        // Start indices are only looked at while stopped [RULE7]
        if (play_start) begin
          state_d = WSC_WAIT_TRIG;
          mode_scen_d = table_scenario_play_mode;
          // Start index by play mode [RULE4] [RULE11]
          idx_d = table_scenario_play_mode ? scenario_start_index : sequence_start_index;
          seq_first_d = idx_d;
          seq_new_d = 1'b1;
          scen_start_d = scenario_start_index;
          scen_loops_d = scen_reload_w; // [RULE13]
        end
      end
      WSC_WAIT_TRIG: begin
        if (trigger_event) begin
          state_d = WSC_RUN;
        end
      end
      WSC_RUN: begin
        seq_loops_d = seq_loops_eff_w; // [RULE14]
        seq_new_d = 1'b0;
        if (done_w) begin
          if (!end_seq_w) begin
            idx_d = idx_q + IDX_ONE;
          end else if (seq_more_w) begin
            // Replay the sequence from its first entry [RULE14]
            seq_loops_d = seq_loops_eff_w - LOOP_ONE;
            idx_d = seq_first_q;
          end else begin
            seq_new_d = 1'b1;
            if (dyn_take_w) begin
              idx_d = dyn_idx_q; // [RULE8]
            end else if (scen_end_w && scen_more_w) begin
              scen_loops_d = scen_loops_q - LOOP_ONE; // [RULE13]
              idx_d = scen_start_q;
            end else if (scen_end_w) begin
              idx_d = scen_start_q;
              scen_loops_d = scen_reload_w;
              // Boundary behaviour by advance mode [RULE12] [RULE15]
              case (adv_q)
                ADV_AUTO: state_d = WSC_RUN;
                ADV_COND: state_d = WSC_WAIT_ADV;
                ADV_REPEAT: state_d = WSC_WAIT_ADV;
                default: state_d = WSC_IDLE;
              endcase
            end else if (mode_scen_q) begin
              idx_d = idx_q + IDX_ONE;
            end else begin
              // Sequence mode keeps replaying the selected sequence
              idx_d = seq_first_q;
            end
            seq_first_d = idx_d;
          end
        end
      end
      WSC_WAIT_ADV: begin
        if (advance_event) begin
          state_d = WSC_RUN;
        end
      end
      default: state_d = WSC_IDLE;
    endcase
    if (play_stop) begin
      state_d = WSC_IDLE;
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= WSC_IDLE;
      idx_q <= '0;
      seq_first_q <= '0;
      seq_new_q <= 1'b0;
      seq_loops_q <= LOOP_ONE;
      scen_loops_q <= LOOP_ONE;
      scen_start_q <= '0;
      mode_scen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      seq_first_q <= seq_first_d;
      seq_new_q <= seq_new_d;
      seq_loops_q <= seq_loops_d;
      scen_loops_q <= scen_loops_d;
      scen_start_q <= scen_start_d;
      mode_scen_q <= mode_scen_d;
    end
  end

  // ****************************************************************
  // Block read
  // ****************************************************************
  // Length zero and requests while busy are ignored
  wire blk_take_w = table_block_read_req && !blk_busy_q && (table_block_read_length != '0);
  wire blk_end_w = blk_busy_q && (blk_left_q == IDX_ONE);

  // One entry per cycle from the requested index onward [RULE3]
  always_ff @(posedge clk) begin
    if (srst) begin
      blk_busy_q <= 1'b0;
      blk_valid_q <= 1'b0;
      blk_last_q <= 1'b0;
      blk_data_q <= '0;
      blk_idx_q <= '0;
      blk_left_q <= '0;
    end else begin
      blk_busy_q <= blk_take_w || (blk_busy_q && !blk_end_w);
      blk_valid_q <= blk_busy_q;
      blk_last_q <= blk_end_w;
      blk_data_q <= blk_busy_q ? tbl.rd_data_b : blk_data_q;
      blk_idx_q <= blk_take_w ? table_block_read_index : blk_idx_q + IDX_ONE;
      blk_left_q <= blk_take_w ? table_block_read_length : blk_left_q - IDX_ONE;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign tbl.wr_en = tbl_wr_en;
  assign tbl.wr_addr = tbl_wr_index[TBL_AW-1:0];
  assign tbl.wr_data = tbl_wr_data;
  assign tbl.rd_addr_a = idx_q[TBL_AW-1:0];
  assign tbl.rd_addr_b = blk_idx_q[TBL_AW-1:0];
  assign blk_busy = blk_busy_q;
  assign blk_valid = blk_valid_q;
  assign blk_last = blk_last_q;
  assign blk_data = blk_data_q;
  assign entry_data = cur_w;
  assign scenario_advance_mode = adv_q;
  assign dynamic_select_enable = dyn_en_q;
  // Status word: reserved zeros, state code, running index [RULE1] [RULE2]
  assign sequencer_state_word = {{STAT_RSV_W{1'b0}}, wsc_state_code(state_q), idx_q};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  wire [1:0] stat_code_w = sequencer_state_word[STAT_STATE_LO+:2];

  property p_stop_idle;
    @(posedge clk) disable iff (srst) play_stop |=> stat_code_w == CODE_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle"); // [RULE1]

  property p_seq_start;
    @(posedge clk) disable iff (srst)
      (state_q == WSC_IDLE && play_start && !play_stop && !table_scenario_play_mode) |=>
      (sequencer_state_word[IDX_W-1:0] == $past(sequence_start_index) &&
      stat_code_w == CODE_WAIT_TRIG);
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("bad sequence start"); // [RULE4] [RULE2]

  property p_scen_start;
    @(posedge clk) disable iff (srst)
      (state_q == WSC_IDLE && play_start && !play_stop && table_scenario_play_mode) |=>
      sequencer_state_word[IDX_W-1:0] == $past(scenario_start_index);
  endproperty
  a_scen_start: assert property (p_scen_start) else $error("bad scenario start"); // [RULE11]

  property p_dyn_rb;
    @(posedge clk) disable iff (srst)
      dynamic_select_enable_wr |=> dynamic_select_enable == $past(dynamic_select_enable_wdata);
  endproperty
  a_dyn_rb: assert property (p_dyn_rb) else $error("dynamic enable readback"); // [RULE6]

  property p_adv_rb;
    @(posedge clk) disable iff (srst)
      scenario_advance_mode_wr |=> scenario_advance_mode == $past(scenario_advance_mode_wdata);
  endproperty
  a_adv_rb: assert property (p_adv_rb) else $error("advance mode readback"); // [RULE12]

  sequence s_blk_take;
    table_block_read_req && !blk_busy && (table_block_read_length != '0);
  endsequence
  sequence s_blk_single;
    blk_busy ##1 (blk_valid && blk_last && !blk_busy);
  endsequence
  property p_blk_one;
    @(posedge clk) disable iff (srst)
      (s_blk_take and (table_block_read_length == IDX_ONE)) |=> s_blk_single;
  endproperty
  a_blk_one: assert property (p_blk_one) else $error("single entry block read"); // [RULE3]

  property p_blk_run;
    @(posedge clk) disable iff (srst)
      (s_blk_take and (table_block_read_length > IDX_ONE)) |=>
      blk_busy ##1 (blk_valid && !blk_last && blk_busy);
  endproperty
  a_blk_run: assert property (p_blk_run) else $error("block read run"); // [RULE3]

  property p_dyn_jump;
    @(posedge clk) disable iff (srst)
      (dyn_take_w && !play_stop) |=> (idx_q == $past(dyn_idx_q) && state_q == WSC_RUN);
  endproperty
  a_dyn_jump: assert property (p_dyn_jump) else $error("dynamic jump"); // [RULE8] [RULE10]

  property p_dyn_off;
    @(posedge clk) disable iff (srst) !dyn_en_q |=> !dyn_pend_q;
  endproperty
  a_dyn_off: assert property (p_dyn_off) else $error("selection kept when off"); // [RULE7]

  property p_dyn_hold;
    @(posedge clk) disable iff (srst)
      (dyn_pend_q && dyn_en_q && !seq_end_w) |=> dyn_pend_q;
  endproperty
  a_dyn_hold: assert property (p_dyn_hold) else $error("choice taken early"); // [RULE5]

  property p_port_sel;
    @(posedge clk) disable iff (srst)
      (port_edge_w && dyn_en_q && !next_entry_select_wr) |=>
      (dyn_pend_q && dyn_idx_q == $past(port_idx_s2_q));
  endproperty
  a_port_sel: assert property (p_port_sel) else $error("port select lost"); // [RULE9]

  property p_seq_loop;
    @(posedge clk) disable iff (srst)
      (done_w && end_seq_w && seq_more_w && !play_stop) |=>
      (idx_q == $past(seq_first_q) && seq_loops_q == $past(seq_loops_eff_w) - LOOP_ONE);
  endproperty
  a_seq_loop: assert property (p_seq_loop) else $error("sequence loop"); // [RULE14]

  property p_scen_loop;
    @(posedge clk) disable iff (srst)
      (scen_end_w && scen_more_w && !play_stop) |=>
      (idx_q == scen_start_q && scen_loops_q == $past(scen_loops_q) - LOOP_ONE);
  endproperty
  a_scen_loop: assert property (p_scen_loop) else $error("scenario loop"); // [RULE13]

  property p_adv_single;
    @(posedge clk) disable iff (srst)
      (scen_end_w && !scen_more_w && adv_q == ADV_SINGLE) |=> state_q == WSC_IDLE;
  endproperty
  a_adv_single: assert property (p_adv_single) else $error("single did not stop"); // [RULE15]

endmodule

// [tb_top.sv]
// Self-checking testbench of the waveform sequence controller
`timescale 1ns/1ps
module tb_top;
  import wsc_pkg::*;
  // ****************************************************************
  // Stimulus and observation signals
  // ****************************************************************
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] ctl = 5'h00; // Pulses: start, stop, trigger, advance, entry done
  logic mode = 1'b0;
  logic [IDX_W-1:0] seq_idx = 25'h0;
  logic [IDX_W-1:0] scen_idx = 25'h0;
  logic [CNT_W-1:0] scen_cnt = 32'h1;
  logic adv_wr = 1'b0;
  logic dyn_wr = 1'b0;
  logic [ADV_W-1:0] adv_wd = 4'h0;
  logic dyn_wd = 1'b0;
  logic sel_wr = 1'b0;
  logic [IDX_W-1:0] sel_idx = 25'h0;
  logic [IDX_W-1:0] port_idx = 25'h0;
  logic port_stb = 1'b0; // Held low after reset until the synchroniser has settled
  logic tw_en = 1'b0;
  logic [IDX_W-1:0] tw_idx = 25'h0;
  logic [ENTRY_W-1:0] tw_data = 64'h0;
  logic br_req = 1'b0;
  logic [IDX_W-1:0] br_idx = 25'h0;
  logic [IDX_W-1:0] br_len = 25'h0;
  logic [ADV_W-1:0] adv_q;
  logic dyn_q;
  logic busy, valid, last;
  logic [ENTRY_W-1:0] bdata, edata;
  logic [CNT_W-1:0] stat;
  int n_fail = 0;
  int checks_done = 0;
  // Entries 4..6 form one sequence; only the first loop count should matter
  logic [63:0] e[3] = '{64'h0000_0000_0000_0002, 64'h0, 64'h4000_0000_0000_0005};

  always #5 clk = ~clk;

  wsc_sequencer i_wsc_sequencer (.clk(clk), .srst(srst), .play_start(ctl[0]),
    .play_stop(ctl[1]), .trigger_event(ctl[2]), .advance_event(ctl[3]), .entry_done(ctl[4]),
    .table_scenario_play_mode(mode), .sequence_start_index(seq_idx),
    .scenario_start_index(scen_idx), .scenario_loop_count(scen_cnt),
    .scenario_advance_mode_wr(adv_wr), .scenario_advance_mode_wdata(adv_wd),
    .scenario_advance_mode(adv_q), .dynamic_select_enable_wr(dyn_wr),
    .dynamic_select_enable_wdata(dyn_wd), .dynamic_select_enable(dyn_q),
    .next_entry_select_wr(sel_wr), .next_entry_select_index(sel_idx),
    .dyn_port_index(port_idx), .dyn_port_strobe(port_stb), .tbl_wr_en(tw_en),
    .tbl_wr_index(tw_idx), .tbl_wr_data(tw_data), .table_block_read_req(br_req),
    .table_block_read_index(br_idx), .table_block_read_length(br_len), .blk_busy(busy),
    .blk_valid(valid), .blk_last(last), .blk_data(bdata), .entry_data(edata),
    .sequencer_state_word(stat));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask
  // Status word: reserved top bits, state code, running index
  task automatic st(input logic [1:0] c, input logic [IDX_W-1:0] i);
    chk(64'(stat), {32'h0, 5'h00, c, i});
  endtask
  // One-cycle pulse, settled outputs sampled after the taking edge
  task automatic pulse(input int k);
    @(posedge clk);
    ctl[k] <= 1'b1;
    @(posedge clk);
    ctl[k] <= 1'b0;
    #1;
  endtask
  // Register write: a=1 advance mode, a=0 dynamic enable
  task automatic reg_wr(input logic a, input logic [ADV_W-1:0] v);
    @(posedge clk);
    adv_wr <= a;
    dyn_wr <= ~a;
    adv_wd <= v;
    dyn_wd <= v[0];
    @(posedge clk);
    adv_wr <= 1'b0;
    dyn_wr <= 1'b0;
    #1;
  endtask
  task automatic twr(input logic [IDX_W-1:0] i, input logic [63:0] d);
    @(posedge clk);
    tw_en <= 1'b1;
    tw_idx <= i;
    tw_data <= d;
    @(posedge clk);
    tw_en <= 1'b0;
  endtask
  task automatic sel(input logic [IDX_W-1:0] i);
    @(posedge clk);
    sel_wr <= 1'b1;
    sel_idx <= i;
    @(posedge clk);
    sel_wr <= 1'b0;
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Watchdog: the whole sequence needs well under a thousand cycles
  // ****************************************************************
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    summarize();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    st(2'h0, 25'h0);
    chk(64'(dyn_q), 64'h0);
    chk(64'(adv_q), 64'h0);
    // Every advance code reads back as written
    for (int v = 0; v < 4; v++) begin
      reg_wr(1'b1, 4'(v));
      chk(64'(adv_q), 64'(v));
    end
    for (int k = 0; k < 3; k++) twr(25'(4 + k), e[k]);
    twr(25'h0A, 64'h4000_0000_0000_0001);
    twr(25'h14, 64'h4000_0000_0000_0001);
    twr(25'h1E, 64'h6000_0000_0000_0001);
    // Block read of three entries, one data beat per cycle
    @(posedge clk);
    br_req <= 1'b1;
    br_idx <= 25'h4;
    br_len <= 25'h3;
    @(posedge clk);
    br_req <= 1'b0;
    #1;
    chk(64'(busy), 64'h1);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      #1;
      chk(64'({valid, last}), 64'({1'b1, k == 2}));
      chk(bdata, e[k]);
    end
    // Single-entry block read: one beat that is both valid and last
    @(posedge clk);
    br_req <= 1'b1;
    br_idx <= 25'h0A;
    br_len <= 25'h1;
    @(posedge clk);
    br_req <= 1'b0;
    #1;
    chk(64'(busy), 64'h1);
    @(posedge clk);
    #1;
    chk(64'({valid, last, busy}), 64'h6);
    chk(bdata, 64'h4000_0000_0000_0001);
    // Sequence mode with a host selection pending across a sequence loop
    reg_wr(1'b0, 4'h1);
    chk(64'(dyn_q), 64'h1);
    seq_idx <= 25'h4;
    pulse(0);
    st(2'h1, 25'h4);
    chk(edata, e[0]);
    pulse(2);
    st(2'h2, 25'h4);
    sel(25'h0A);
    pulse(4);
    st(2'h2, 25'h5);
    pulse(4);
    pulse(4);
    st(2'h2, 25'h4);
    pulse(4);
    pulse(4);
    pulse(4);
    st(2'h2, 25'h0A);
    // External port picks the next entry
    @(posedge clk);
    port_idx <= 25'h14;
    port_stb <= 1'b1;
    repeat (6) @(posedge clk);
    port_stb <= 1'b0;
    pulse(4);
    st(2'h2, 25'h14);
    // With dynamic selection off a host selection is dropped
    reg_wr(1'b0, 4'h0);
    chk(64'(dyn_q), 64'h0);
    sel(25'h0A);
    pulse(4);
    st(2'h2, 25'h14);
    pulse(1);
    chk(64'(stat[26:25]), 64'(CODE_IDLE));
    // Scenario mode: two scenario loops, then single stops
    mode <= 1'b1;
    scen_idx <= 25'h1E;
    scen_cnt <= 32'h2;
    reg_wr(1'b1, ADV_SINGLE);
    pulse(0);
    st(2'h1, 25'h1E);
    pulse(2);
    pulse(4);
    st(2'h2, 25'h1E);
    pulse(4);
    chk(64'(stat[26:25]), 64'(CODE_IDLE));
    // Conditional mode parks until an advance event
    scen_cnt <= 32'h1;
    reg_wr(1'b1, ADV_COND);
    pulse(0);
    pulse(2);
    pulse(4);
    st(2'h3, 25'h1E);
    pulse(3);
    st(2'h2, 25'h1E);
    // Auto mode restarts the scenario at once; a reserved code stops like single
    reg_wr(1'b1, ADV_AUTO);
    pulse(4);
    st(2'h2, 25'h1E);
    reg_wr(1'b1, 4'h5);
    pulse(4);
    chk(64'(stat[26:25]), 64'(CODE_IDLE));
    pulse(1);
    summarize();
  end
endmodule
